// File: src/nfh_pkg.sv
// Package for the NOR flash mode-command host controller
package nfh_pkg;
   // Command word addresses and data
   localparam logic [10:0] NFH_ADDR_UNLOCK1 = 11'h555;
   localparam logic [10:0] NFH_ADDR_UNLOCK2 = 11'h2aa;
   localparam logic [10:0] NFH_ADDR_ANY = 11'h000;
   localparam logic [15:0] NFH_DATA_UNLOCK1 = 16'h00aa;
   localparam logic [15:0] NFH_DATA_UNLOCK2 = 16'h0055;
   localparam logic [15:0] NFH_DATA_BYPASS_ENTRY = 16'h0020;
   localparam logic [15:0] NFH_DATA_PROGRAM_SETUP = 16'h00a0;
   localparam logic [15:0] NFH_DATA_EXIT1 = 16'h0090;
   localparam logic [15:0] NFH_DATA_EXIT2 = 16'h0000;
   localparam logic [15:0] NFH_DATA_SECURE_ENTRY = 16'h0088;
   localparam logic [15:0] NFH_DATA_AUTOSELECT = 16'h0090;
   localparam logic [15:0] NFH_DATA_RESET = 16'h00f0;
   // Autoselect word addresses
   localparam logic [10:0] NFH_AS_MAKER = 11'h000;
   localparam logic [10:0] NFH_AS_SECURE = 11'h003;
   localparam logic [10:0] NFH_AS_PROTECT = 11'h002;
   localparam int NFH_IND_BIT = 7;
   localparam int NFH_SECURE_WORDS = 128;
   localparam int NFH_SERIAL_WORDS = 8;
   // Host register map (word index on the software port)
   localparam logic [3:0] NFH_REG_CMD = 4'h0;
   localparam logic [3:0] NFH_REG_ADDR = 4'h1;
   localparam logic [3:0] NFH_REG_WDATA = 4'h2;
   localparam logic [3:0] NFH_REG_STATUS = 4'h3;
   localparam logic [3:0] NFH_REG_RDATA = 4'h4;
   // Command codes written to the command register
   localparam logic [3:0] NFH_OP_READ = 4'h1;
   localparam logic [3:0] NFH_OP_BYPASS_ENTER = 4'h2;
   localparam logic [3:0] NFH_OP_BYPASS_PROG = 4'h3;
   localparam logic [3:0] NFH_OP_BYPASS_EXIT = 4'h4;
   localparam logic [3:0] NFH_OP_SECURE_ENTER = 4'h5;
   localparam logic [3:0] NFH_OP_SECURE_EXIT = 4'h6;
   localparam logic [3:0] NFH_OP_AUTOSEL_ENTER = 4'h7;
   localparam logic [3:0] NFH_OP_RESET = 4'h8;
   localparam logic [3:0] NFH_OP_PROGRAM = 4'h9;
   // Bus timing in ns and cycles at 20 MHz
   localparam int NFH_CLK_NS = 50;
   localparam int NFH_PULSE_NS = 100;
   localparam int NFH_PULSE_CYC = (NFH_PULSE_NS + NFH_CLK_NS - 1) / NFH_CLK_NS;
   localparam int NFH_READ_NS = 150;
   localparam int NFH_READ_CYC = (NFH_READ_NS + NFH_CLK_NS - 1) / NFH_CLK_NS;
   // Mode of the device as tracked by the host
   typedef enum logic [3:0] {
      NFH_MODE_READ = 4'b0001,
      NFH_MODE_BYPASS = 4'b0010,
      NFH_MODE_SECURE = 4'b0100,
      NFH_MODE_AUTOSEL = 4'b1000
   } nfh_mode_type;
   // One bus cycle toward the flash
   typedef struct packed {
      logic [25:0] addr;
      logic [15:0] data;
   } nfh_cycle_type;
endpackage

// File: src/nfh_host.sv
// Host controller issuing NOR flash mode command sequences
//
// What this block does
// - Bypass entry: two unlock writes then 0020h.
// - Bypass program: 00A0h anywhere, then address and data.
// - Bypass exit: 90h then 00h, any address.
// - Secured entry: two unlock writes then 0088h.
// - Secured exit: unlocks, 0090h at command address, 0000h.
// - Autoselect by high voltage on an address line or by command.
// - Autoselect command only when device is not busy.
// - Reset command leaves autoselect back to read.
// - Protection check puts sector address on top address bits.
// - Software reset is 00F0h at any address.
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module nfh_host
   import nfh_pkg::*;
#(
   parameter int ADDR_W = 26,
   parameter int PULSE_CYC = NFH_PULSE_CYC,
   parameter int READ_CYC = NFH_READ_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic nrst,
   // Software register port
   input wire logic [3:0] sw_addr,
   input wire logic [31:0] sw_wdata,
   input wire logic sw_wr,
   input wire logic sw_rd,
   output logic [31:0] sw_rdata,
   // Flash bus
   output logic [ADDR_W-1:0] flash_addr,
   output logic [15:0] flash_dq_out,
   output logic flash_dq_oe_n,
   input wire logic [15:0] flash_dq_in,
   output logic flash_ce_n,
   output logic flash_oe_n,
   output logic flash_we_n,
   input wire logic flash_ready,
   // High-voltage autoselect request toward the programmer rig
   output logic identify_high_voltage
);
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_SETUP = 5'b00010,
      ST_WRITE = 5'b00100,
      ST_READ = 5'b01000,
      ST_HOLD = 5'b10000
   } nfh_state_type;

   nfh_state_type state_reg, state_next;
   nfh_mode_type mode_reg;
   nfh_cycle_type seq_reg [0:3];
   logic [2:0] seq_len_reg;
   logic [2:0] seq_idx_reg;
   logic seq_read_reg;
   logic [3:0] op_reg;
   logic [7:0] cnt_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic [15:0] wdata_reg;
   logic [15:0] rdata_reg;
   logic refused_reg;
   logic hv_reg;

   // Build an unlock-style bus cycle
   function automatic nfh_cycle_type mk(input logic [10:0] a, input logic [15:0] d);
      mk.addr = {{(26 - 11){1'b0}}, a};
      mk.data = d;
   endfunction

   wire busy = (state_reg != ST_IDLE);
   wire cmd_wr = sw_wr && (sw_addr == NFH_REG_CMD) && !busy;
   wire [3:0] cmd_op = sw_wdata[3:0];
   wire busy_refuse = (cmd_op == NFH_OP_SECURE_ENTER || cmd_op == NFH_OP_AUTOSEL_ENTER)
      && !flash_ready;
   // no bypass while secured mode active; bypass takes only its own set, read and reset
   wire mode_refuse =
      (mode_reg == NFH_MODE_SECURE && (cmd_op == NFH_OP_BYPASS_ENTER
         || cmd_op == NFH_OP_BYPASS_PROG)) ||
      (mode_reg == NFH_MODE_BYPASS && (cmd_op == NFH_OP_SECURE_ENTER
         || cmd_op == NFH_OP_AUTOSEL_ENTER || cmd_op == NFH_OP_PROGRAM
         || cmd_op == NFH_OP_SECURE_EXIT)) ||
      (mode_reg != NFH_MODE_BYPASS && (cmd_op == NFH_OP_BYPASS_PROG
         || cmd_op == NFH_OP_BYPASS_EXIT));
   wire cmd_go = cmd_wr && !busy_refuse && !mode_refuse;
   wire cnt_done = (cnt_reg == 8'h00);
   wire last_cycle = (seq_idx_reg == seq_len_reg - 3'h1);
   // secured window keeps only the low 128-word address bits
   wire [ADDR_W-1:0] secure_mask = ADDR_W'(NFH_SECURE_WORDS - 1);
   wire [ADDR_W-1:0] eff_addr = (mode_reg == NFH_MODE_SECURE) ? (addr_reg & secure_mask)
      : addr_reg;
   wire nfh_cycle_type cur = seq_reg[seq_idx_reg[1:0]];

   // Software readback
   wire [31:0] status_word = {20'h0, hv_reg, refused_reg, op_reg, mode_reg, 1'b0, busy};
   wire [31:0] rd_mux = (sw_addr == NFH_REG_STATUS) ? status_word :
      (sw_addr == NFH_REG_RDATA) ? {16'h0, rdata_reg} :
      (sw_addr == NFH_REG_ADDR) ? 32'(addr_reg) :
      (sw_addr == NFH_REG_WDATA) ? {16'h0, wdata_reg} : 32'h0;

   // Sequencer next state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: if (cmd_go) state_next = ST_SETUP;
         ST_SETUP: state_next = seq_read_reg && last_cycle ? ST_READ : ST_WRITE;
         ST_WRITE: if (cnt_done) state_next = ST_HOLD;
         ST_READ: if (cnt_done) state_next = ST_HOLD;
         ST_HOLD: state_next = last_cycle ? ST_IDLE : ST_SETUP;
         default: state_next = ST_IDLE;
      endcase
   end

   // Software register writes and readback
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         addr_reg <= '0;
         wdata_reg <= 16'h0;
         sw_rdata <= 32'h0;
         hv_reg <= 1'b0;
      end else begin
         if (sw_wr && sw_addr == NFH_REG_ADDR) addr_reg <= sw_wdata[ADDR_W-1:0];
         if (sw_wr && sw_addr == NFH_REG_WDATA) wdata_reg <= sw_wdata[15:0];
         if (sw_wr && sw_addr == NFH_REG_STATUS) hv_reg <= sw_wdata[9];
         sw_rdata <= sw_rd ? rd_mux : 32'h0;
      end
   end

   // Load a command sequence
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < 4; i++) seq_reg[i] <= '0;
         seq_len_reg <= 3'h1;
         seq_read_reg <= 1'b0;
         op_reg <= 4'h0;
         refused_reg <= 1'b0;
      end else if (cmd_wr) begin
         op_reg <= cmd_op;
         refused_reg <= !cmd_go;
         seq_read_reg <= 1'b0;
         seq_reg[0] <= mk(NFH_ADDR_UNLOCK1, NFH_DATA_UNLOCK1);
         seq_reg[1] <= mk(NFH_ADDR_UNLOCK2, NFH_DATA_UNLOCK2);
         seq_reg[2] <= '{addr: 26'(eff_addr), data: wdata_reg};
         seq_reg[3] <= '{addr: 26'(eff_addr), data: wdata_reg};
         seq_len_reg <= 3'h3;
         case (cmd_op)
            NFH_OP_BYPASS_ENTER: seq_reg[2] <= mk(NFH_ADDR_UNLOCK1, NFH_DATA_BYPASS_ENTRY);
            NFH_OP_BYPASS_PROG: begin
               seq_reg[0] <= mk(NFH_ADDR_ANY, NFH_DATA_PROGRAM_SETUP);
               seq_reg[1] <= '{addr: 26'(eff_addr), data: wdata_reg};
               seq_len_reg <= 3'h2;
            end
            NFH_OP_BYPASS_EXIT: begin
               seq_reg[0] <= mk(NFH_ADDR_ANY, NFH_DATA_EXIT1);
               seq_reg[1] <= mk(NFH_ADDR_ANY, NFH_DATA_EXIT2);
               seq_len_reg <= 3'h2;
            end
            NFH_OP_SECURE_ENTER: seq_reg[2] <= mk(NFH_ADDR_UNLOCK1, NFH_DATA_SECURE_ENTRY);
            NFH_OP_SECURE_EXIT: begin
               seq_reg[2] <= mk(NFH_ADDR_UNLOCK1, NFH_DATA_EXIT1);
               seq_reg[3] <= mk(NFH_ADDR_ANY, NFH_DATA_EXIT2);
               seq_len_reg <= 3'h4;
            end
            // autoselect entry at first unlock address
            NFH_OP_AUTOSEL_ENTER: seq_reg[2] <= mk(NFH_ADDR_UNLOCK1, NFH_DATA_AUTOSELECT);
            NFH_OP_RESET: begin
               seq_reg[0] <= mk(NFH_ADDR_ANY, NFH_DATA_RESET);
               seq_len_reg <= 3'h1;
            end
            // Normal four-cycle program
            NFH_OP_PROGRAM: begin
               seq_reg[2] <= mk(NFH_ADDR_UNLOCK1, NFH_DATA_PROGRAM_SETUP);
               seq_len_reg <= 3'h4;
            end
            // plain read; sector address comes from the address register
            NFH_OP_READ: begin
               seq_reg[0] <= '{addr: 26'(eff_addr), data: 16'h0};
               seq_len_reg <= 3'h1;
               seq_read_reg <= 1'b1;
            end
            default: seq_len_reg <= 3'h1;
         endcase
      end
   end

   // Track the device mode
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mode_reg <= NFH_MODE_READ;
      end else if (state_reg == ST_HOLD && last_cycle) begin
         case (op_reg)
            NFH_OP_BYPASS_ENTER: mode_reg <= NFH_MODE_BYPASS;
            NFH_OP_SECURE_ENTER: mode_reg <= NFH_MODE_SECURE;
            NFH_OP_AUTOSEL_ENTER: mode_reg <= NFH_MODE_AUTOSEL;
            NFH_OP_RESET: if (mode_reg == NFH_MODE_AUTOSEL) mode_reg <= NFH_MODE_READ;
            NFH_OP_BYPASS_EXIT,
            NFH_OP_SECURE_EXIT: mode_reg <= NFH_MODE_READ;
            default: mode_reg <= mode_reg;
         endcase
      end
   end

   // Bus cycle sequencer
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= ST_IDLE;
         seq_idx_reg <= 3'h0;
         cnt_reg <= 8'h0;
         rdata_reg <= 16'h0;
      end else begin
         state_reg <= state_next;
         if (state_reg == ST_IDLE) seq_idx_reg <= 3'h0;
         if (state_reg == ST_SETUP) cnt_reg <= 8'(seq_read_reg ? READ_CYC : PULSE_CYC);
         else if (!cnt_done) cnt_reg <= cnt_reg - 8'h1;
         if (state_reg == ST_READ && cnt_done) rdata_reg <= flash_dq_in;
         if (state_reg == ST_HOLD) seq_idx_reg <= seq_idx_reg + 3'h1;
      end
   end

   // Flash pin drive
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         flash_addr <= '0;
         flash_dq_out <= 16'h0;
      end else if (state_reg == ST_SETUP) begin
         flash_addr <= ADDR_W'(cur.addr);
         flash_dq_out <= cur.data;
      end
   end

   assign flash_ce_n = !(state_reg == ST_WRITE || state_reg == ST_READ);
   assign flash_we_n = !(state_reg == ST_WRITE);
   assign flash_oe_n = !(state_reg == ST_READ);
   assign flash_dq_oe_n = !(state_reg == ST_SETUP || state_reg == ST_WRITE
      || state_reg == ST_HOLD) || seq_read_reg;
   assign identify_high_voltage = hv_reg;
endmodule
`default_nettype wire

// File: dv/nfh_props.sv
// Port checker for the NOR flash host controller
`timescale 1ns/100ps
`default_nettype none
module nfh_props
   import nfh_pkg::*;
#(
   parameter int ADDR_W = 26,
   parameter int PULSE_CYC = NFH_PULSE_CYC,
   parameter int READ_CYC = NFH_READ_CYC
) (
   // Clock, reset, software read
   input wire logic clk,
   input wire logic nrst,
   input wire logic sw_rd,
   input wire logic [31:0] sw_rdata,
   // Flash bus
   input wire logic [ADDR_W-1:0] flash_addr,
   input wire logic [15:0] flash_dq_out,
   input wire logic flash_dq_oe_n,
   input wire logic flash_ce_n,
   input wire logic flash_oe_n,
   input wire logic flash_we_n,
   input wire logic identify_high_voltage
);
   logic [7:0] we_cnt;
   logic [7:0] oe_cnt;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // Strobe low-time counters
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         we_cnt <= 8'h00;
         oe_cnt <= 8'h00;
      end else begin
         we_cnt <= flash_we_n ? 8'h00 : we_cnt + 8'h01;
         oe_cnt <= flash_oe_n ? 8'h00 : oe_cnt + 8'h01;
      end
   end
   a_idle_after_reset: assert property ($rose(nrst) |-> flash_ce_n && flash_we_n
      && flash_oe_n && flash_dq_oe_n) else $error("strobes active after reset");
   a_strobe_excl: assert property (!(!flash_we_n && !flash_oe_n))
      else $error("write and read strobes together");
   a_we_width: assert property ($rose(flash_we_n) |-> we_cnt == PULSE_CYC + 1)
      else $error("write pulse length wrong");
   a_oe_width: assert property ($rose(flash_oe_n) |-> oe_cnt == READ_CYC + 1)
      else $error("read pulse length wrong");
   a_write_drives: assert property (!flash_we_n |-> !flash_dq_oe_n && !flash_ce_n)
      else $error("write without driven data");
   a_read_releases: assert property (!flash_oe_n |-> flash_dq_oe_n && !flash_ce_n)
      else $error("host drives data during read");
   a_write_stable: assert property (!flash_we_n && !$past(flash_we_n) |->
      $stable(flash_addr) && $stable(flash_dq_out)) else $error("write cycle not stable");
   a_rdata_idle: assert property (!$past(sw_rd) |-> sw_rdata == 32'h0)
      else $error("read data outside its cycle");
   cover property ($fell(flash_we_n));
   cover property ($fell(flash_oe_n));
   cover property ($rose(identify_high_voltage));
endmodule
bind nfh_host nfh_props #(.ADDR_W(ADDR_W), .PULSE_CYC(PULSE_CYC), .READ_CYC(READ_CYC)) props_u (
   .clk(clk), .nrst(nrst), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .flash_addr(flash_addr),
   .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n), .flash_ce_n(flash_ce_n),
   .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
   .identify_high_voltage(identify_high_voltage));
`default_nettype wire

// File: dv/nfh_flash_model.sv
// Behavioural model of the flash command interface
`timescale 1ns/100ps
`default_nettype none
module nfh_flash_model
   import nfh_pkg::*;
#(
   // Maker code value is arbitrary
   parameter logic [7:0] MAKER = 8'h3c,
   // set when the secured region is locked
   parameter logic LOCKED = 1'b0
) (
   // Bus from the host
   input wire logic [25:0] addr,
   input wire logic [15:0] dq_in,
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic busy,
   // Toward the host
   output logic [15:0] dq_out,
   output logic ready
);
   logic [15:0] arr [256];
   logic [15:0] sec [128];
   logic [10:0] ha1, ha2, a;
   logic [15:0] hd1, hd2, rv, last;
   logic pend, unl, wsel;
   nfh_mode_type mode;
   initial begin
      for (int i = 0; i < 256; i++) arr[i] = 16'hffff;
      // serial number in the first words
      for (int i = 0; i < 128; i++) sec[i] = 16'hc000 + 16'(i);
      {ha1, ha2, hd1, hd2, last, pend, wsel} = '0;
      mode = NFH_MODE_READ;
   end
   assign ready = !busy;
   // Chip select seen inside the write strobe, once both have settled
   always @(negedge we_n) begin
      #1 wsel = !ce_n;
   end
   // Decode each write on the rising strobe
   always @(posedge we_n) begin
      if (wsel) begin
         wsel = 1'b0;
         a = addr[10:0];
         unl = ha2 == 11'h555 && hd2 == 16'h00aa && ha1 == 11'h2aa && hd1 == 16'h0055;
         unl = unl && a == 11'h555;
         if (pend) begin
            // program only clears bits; locked region stays
            if (mode == NFH_MODE_SECURE) begin
               if (!LOCKED) sec[addr[6:0]] &= dq_in;
            end else arr[addr[7:0]] &= dq_in;
            pend = 1'b0;
         end else if ((mode == NFH_MODE_BYPASS || mode == NFH_MODE_SECURE) && hd1 == 16'h0090
            && dq_in == 16'h0000) begin
            mode = NFH_MODE_READ;
         end else if (mode == NFH_MODE_AUTOSEL && dq_in == 16'h00f0) begin
            mode = NFH_MODE_READ;
         end else if (dq_in == 16'h00a0 && (mode == NFH_MODE_BYPASS || unl)) begin
            pend = 1'b1;
         end else if (unl && mode == NFH_MODE_READ) begin
            if (dq_in == 16'h0020) mode = NFH_MODE_BYPASS;
            if (dq_in == 16'h0088 && !busy) mode = NFH_MODE_SECURE;
            if (dq_in == 16'h0090 && !busy) mode = NFH_MODE_AUTOSEL;
         end
         {ha2, hd2, ha1, hd1} = {ha1, hd1, a, dq_in};
      end
   end
   assign rv = mode == NFH_MODE_SECURE ? sec[addr[6:0]] : mode != NFH_MODE_AUTOSEL ?
      arr[addr[7:0]] : addr[7:0] == 8'h00 ? {8'h00, MAKER} : {8'h00, LOCKED, 7'h19};
   // Released bus shows the inverse of the last word
   always @(posedge oe_n) last = rv;
   assign dq_out = (!ce_n && !oe_n) ? rv : ~last;
endmodule
`default_nettype wire

// File: dv/tb_nfh_host.sv
// Testbench for the NOR flash host controller
`timescale 1ns/100ps
`default_nettype none
module tb_nfh_host
   import nfh_pkg::*;
;
   // Maker code value is arbitrary
   localparam logic [7:0] MAKER = 8'h3c;
   logic clk = 1'b0, nrst = 1'b0, sw_wr = 1'b0, sw_rd = 1'b0, flash_busy = 1'b0;
   logic [3:0] sw_addr = 4'h0;
   logic [31:0] sw_wdata = 32'h0, sw_rdata, rd;
   logic [25:0] flash_addr;
   logic [15:0] flash_dq_out, flash_dq_in;
   logic flash_dq_oe_n, flash_ce_n, flash_oe_n, flash_we_n, flash_ready, hv;
   int miscompares = 0;
   int samples_checked = 0;
   always #25 clk = ~clk;
   nfh_host dut_u (.clk(clk), .nrst(nrst), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
      .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .flash_addr(flash_addr),
      .flash_dq_out(flash_dq_out), .flash_dq_oe_n(flash_dq_oe_n), .flash_dq_in(flash_dq_in),
      .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
      .flash_ready(flash_ready), .identify_high_voltage(hv));
   nfh_flash_model #(.MAKER(MAKER)) flash_u (.addr(flash_addr), .dq_in(flash_dq_out),
      .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .busy(flash_busy),
      .dq_out(flash_dq_in), .ready(flash_ready));
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic sw_write(input logic [3:0] a, input logic [31:0] d);
      sw_addr <= a;
      sw_wdata <= d;
      sw_wr <= 1'b1;
      @(posedge clk);
      sw_wr <= 1'b0;
      @(posedge clk);
   endtask
   task automatic sw_read(input logic [3:0] a, output logic [31:0] d);
      sw_addr <= a;
      sw_rd <= 1'b1;
      @(posedge clk);
      sw_rd <= 1'b0;
      @(negedge clk);
      d = sw_rdata;
      @(posedge clk);
   endtask
   task automatic run_op(input logic [3:0] op, input logic [25:0] a, input logic [15:0] d);
      int n;
      sw_write(NFH_REG_ADDR, {6'h0, a});
      sw_write(NFH_REG_WDATA, {16'h0, d});
      sw_write(NFH_REG_CMD, {28'h0, op});
      n = 0;
      do begin
         sw_read(NFH_REG_STATUS, rd);
         n++;
      end while (rd[0] !== 1'b0 && n < 100);
      if (rd[0] !== 1'b0) miscompares++;
   endtask
   task automatic expect_stat(input nfh_mode_type m, input logic r);
      sw_read(NFH_REG_STATUS, rd);
      check({27'h0, rd[10], rd[5:2]}, {27'h0, r, m});
   endtask
   task automatic expect_word(input logic [25:0] a, input logic [15:0] w);
      run_op(NFH_OP_READ, a, 16'h0);
      sw_read(NFH_REG_RDATA, rd);
      check(rd, {16'h0, w});
   endtask
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Watchdog against a hung sequence
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      print_verdict;
   end
   // Main sequence
   initial begin
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      expect_stat(NFH_MODE_READ, 1'b0);
      run_op(NFH_OP_BYPASS_PROG, 26'h5, 16'h1234);
      expect_stat(NFH_MODE_READ, 1'b1);
      run_op(NFH_OP_BYPASS_ENTER, 26'h0, 16'h0);
      expect_stat(NFH_MODE_BYPASS, 1'b0);
      run_op(NFH_OP_BYPASS_PROG, 26'h5, 16'h1234);
      run_op(NFH_OP_BYPASS_PROG, 26'h5, 16'h00ff);
      run_op(NFH_OP_SECURE_ENTER, 26'h0, 16'h0);
      expect_stat(NFH_MODE_BYPASS, 1'b1);
      run_op(NFH_OP_BYPASS_EXIT, 26'h0, 16'h0);
      expect_stat(NFH_MODE_READ, 1'b0);
      expect_word(26'h5, 16'h0034);
      run_op(NFH_OP_PROGRAM, 26'h6, 16'h0f0f);
      expect_word(26'h6, 16'h0f0f);
      run_op(NFH_OP_SECURE_ENTER, 26'h0, 16'h0);
      expect_stat(NFH_MODE_SECURE, 1'b0);
      run_op(NFH_OP_BYPASS_ENTER, 26'h0, 16'h0);
      expect_stat(NFH_MODE_SECURE, 1'b1);
      expect_word(26'h85, 16'hc005);
      run_op(NFH_OP_SECURE_EXIT, 26'h0, 16'h0);
      expect_stat(NFH_MODE_READ, 1'b0);
      expect_word(26'h5, 16'h0034);
      run_op(NFH_OP_AUTOSEL_ENTER, 26'h0, 16'h0);
      expect_stat(NFH_MODE_AUTOSEL, 1'b0);
      expect_word(26'h0, {8'h00, MAKER});
      expect_word(26'h3, 16'h0019);
      run_op(NFH_OP_RESET, 26'h0, 16'h0);
      expect_stat(NFH_MODE_READ, 1'b0);
      flash_busy <= 1'b1;
      run_op(NFH_OP_SECURE_ENTER, 26'h0, 16'h0);
      expect_stat(NFH_MODE_READ, 1'b1);
      run_op(NFH_OP_AUTOSEL_ENTER, 26'h0, 16'h0);
      expect_stat(NFH_MODE_READ, 1'b1);
      flash_busy <= 1'b0;
      sw_write(NFH_REG_STATUS, 32'h200);
      check({31'h0, hv}, 32'h1);
      sw_read(NFH_REG_STATUS, rd);
      check({31'h0, rd[11]}, 32'h1);
      print_verdict;
   end
endmodule
`default_nettype wire
